// ---- rtl/smbus_charger_params.svh ----
// Constants shared by the charger SMBus slave and its host end
`ifndef SMBUS_CHARGER_PARAMS_SVH
`define SMBUS_CHARGER_PARAMS_SVH
`define SLAVE_ADDR        7'h09
`define CMD_CONFIG        8'h12
`define CMD_BATT_CURRENT  8'h14
`define CMD_BATT_VOLTAGE  8'h15
`define CMD_ADPT_CURRENT  8'h3f
`define CMD_MAKER_CODE    8'hfe
`define CMD_PART_CODE     8'hff
`define RST_CONFIG        16'h7904
`define RST_BATT_CURRENT  16'h0000
`define RST_BATT_VOLTAGE  16'h0000
`define RST_ADPT_CURRENT  16'h1000
`define MASK_BATT_CURRENT 16'h1fc0
`define MASK_BATT_VOLTAGE 16'h7ff0
`define MASK_ADPT_CURRENT 16'h1f80
`define MASK_CONFIG       16'hffe7
`define REF_CLK_MHZ       40
`define SCL_HALF_NS       2500
`define SCL_HALF_CYC      ((`SCL_HALF_NS * `REF_CLK_MHZ) / 1000)
`endif

// ---- rtl/smbus_charger_pkg.sv ----
// Types shared by the charger SMBus ends
package smbus_charger_pkg;
	typedef enum logic [3:0] {
		SL_IDLE, SL_ADDR, SL_ACK, SL_CMD, SL_DLO, SL_DHI, SL_TX, SL_MACK,
		SL_SKIP
	} slave_state_t;
	typedef enum logic [3:0] {
		HM_IDLE, HM_START, HM_BIT, HM_RSTART, HM_STOP, HM_DONE
	} host_state_t;
endpackage

// ---- rtl/smbus_charger_if.sv ----
// Two-wire bus joining the charger slave and the host master
`timescale 1ns/10ps
interface smbus_charger_if;
	logic scl_out;
	logic scl_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic scl;
	logic sda;
	assign scl = !(scl_oe && !scl_out);
	assign sda = !((sda_dev_oe && !sda_dev_out) ||
		(sda_host_oe && !sda_host_out));
	modport device (input scl, input sda, output sda_dev_out,
		output sda_dev_oe);
	modport host (input scl, input sda, output scl_out, output scl_oe,
		output sda_host_out, output sda_host_oe);
endinterface // smbus_charger_if

// ---- rtl/smbus_sync2.sv ----
// Two-flop synchroniser with edge outputs for the bus lines
`timescale 1ns/10ps
module smbus_sync2 (
	input  wire logic i_ref_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_async,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_reg <= 1'h1;
			sync_reg <= 1'h1;
			last_reg <= 1'h1;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end
	assign o_level = sync_reg;
	assign o_rise  = sync_reg && !last_reg;
	assign o_fall  = !sync_reg && last_reg;
endmodule // smbus_sync2

// ---- rtl/smbus_charger_slave.sv ----
// Charger SMBus slave: word protocols and setting registers
//
// How it works
// (R1) Answer only slave address 0001001
// (R2) Never master: SCL never driven
// (R3) Only Write-Word and Read-Word, 16-bit words
// (R4) Silent unless supply and adapter detect valid
// (R5) Master opens each transaction with START
// (R6) Master closes with STOP; bus freed
// (R7) SDA changes only while SCL low
// (R8) Bytes MSB first, sampled on SCL rise
// (R9) Nine clocks per byte, receiver acknowledges
// (R10) Write: addr, command, two data, ACKs
// (R11) Read: repeated START, two bytes, NACK last
// (R12) ACK low, NACK high; read bit high
// (R13) Commands 12,14,15,3F select setting words
// (R14) Charge current 7 bits, reset 0000
// (R15) Charge voltage 11 bits, reset 0000
// (R16) Input current 6 bits, reset 1000
// (R17) Identification words at FF and FE
// (R18) Identification words read-only, fixed constant
// (R19) Options word writable whenever bus enabled
// (R20) First data byte low, second high
// (R21) Writes to other commands change nothing
`timescale 1ns/10ps
`include "smbus_charger_params.svh"
module smbus_charger_slave #(
	parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
	parameter logic [15:0] PART_CODE  = 16'h005a  // Arbitrary value
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_supply_ok,
	input  wire logic        i_adapter_detect_input,
	smbus_charger_if.device  bus,
	output logic [15:0]      o_charger_config_word,
	output logic [15:0]      o_battery_current_setpoint,
	output logic [15:0]      o_battery_voltage_setpoint,
	output logic [15:0]      o_adapter_current_setpoint
);
	logic scl;
	logic scl_rise;
	logic scl_fall;
	logic sda;
	logic sda_rise;
	logic sda_fall;
	logic sup_meta_reg;
	logic sup_reg;
	logic adp_meta_reg;
	logic adp_reg;
	logic enabled;
	smbus_charger_pkg::slave_state_t state_reg;
	smbus_charger_pkg::slave_state_t after_ack_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  cmd_reg;
	logic [7:0]  lo_reg;
	logic        cmd_seen_reg;
	logic        tx_hi_reg;
	logic [15:0] tx_word_reg;
	logic        sda_drive_reg;
	logic        sda_drive_next;
	logic [7:0]  rx_byte;
	logic        start_cond;
	logic        stop_cond;

	smbus_sync2 u_scl (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_async(bus.scl), .o_level(scl), .o_rise(scl_rise),
		.o_fall(scl_fall));
	smbus_sync2 u_sda (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_async(bus.sda), .o_level(sda), .o_rise(sda_rise),
		.o_fall(sda_fall));

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sup_meta_reg <= 1'h0;
			sup_reg      <= 1'h0;
			adp_meta_reg <= 1'h0;
			adp_reg      <= 1'h0;
		end else begin
			sup_meta_reg <= i_supply_ok;
			sup_reg      <= sup_meta_reg;
			adp_meta_reg <= i_adapter_detect_input;
			adp_reg      <= adp_meta_reg;
		end
	end
	assign enabled = sup_reg && adp_reg; // R4

	function automatic logic [15:0] read_word(input logic [7:0] cmd);
		case (cmd)
			`CMD_CONFIG:       read_word = o_charger_config_word; // R13
			`CMD_BATT_CURRENT: read_word = o_battery_current_setpoint;
			`CMD_BATT_VOLTAGE: read_word = o_battery_voltage_setpoint;
			`CMD_ADPT_CURRENT: read_word = o_adapter_current_setpoint;
			`CMD_MAKER_CODE:   read_word = MAKER_CODE; // R17 R18
			`CMD_PART_CODE:    read_word = PART_CODE;
			default:           read_word = 16'hffff;
		endcase
	endfunction

	assign rx_byte    = {shift_reg[6:0], sda};
	assign start_cond = sda_fall && scl; // R5
	assign stop_cond  = sda_rise && scl; // R6

	// Bit engine: samples on SCL rise, changes SDA after SCL fall
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg     <= smbus_charger_pkg::SL_IDLE;
			after_ack_reg <= smbus_charger_pkg::SL_IDLE;
			bit_cnt_reg   <= 4'h0;
			shift_reg     <= 8'h00;
			cmd_reg       <= 8'h00;
			lo_reg        <= 8'h00;
			cmd_seen_reg  <= 1'h0;
			tx_hi_reg     <= 1'h0;
			tx_word_reg   <= 16'h0000;
		end else if (!enabled || stop_cond) begin
			state_reg    <= smbus_charger_pkg::SL_IDLE; // R4 R6
			cmd_seen_reg <= 1'h0;
		end else if (start_cond) begin
			state_reg   <= smbus_charger_pkg::SL_ADDR; // R11
			bit_cnt_reg <= 4'h0;
		end else if (scl_rise) begin
			case (state_reg)
			smbus_charger_pkg::SL_ADDR,
			smbus_charger_pkg::SL_CMD,
			smbus_charger_pkg::SL_DLO,
			smbus_charger_pkg::SL_DHI: begin
				shift_reg   <= rx_byte; // R8
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (bit_cnt_reg == 4'h7) begin
					bit_cnt_reg <= 4'h0;
					state_reg   <= smbus_charger_pkg::SL_ACK; // R9
					case (state_reg)
					smbus_charger_pkg::SL_ADDR: begin
						if (rx_byte[7:1] != `SLAVE_ADDR) begin
							state_reg <= smbus_charger_pkg::SL_SKIP; // R1
						end else if (rx_byte[0] && cmd_seen_reg) begin
							after_ack_reg <= smbus_charger_pkg::SL_TX; // R12
							tx_word_reg   <= read_word(cmd_reg);
							tx_hi_reg     <= 1'h0;
						end else if (rx_byte[0]) begin
							state_reg <= smbus_charger_pkg::SL_SKIP; // R3
						end else begin
							after_ack_reg <= smbus_charger_pkg::SL_CMD;
						end
					end
					smbus_charger_pkg::SL_CMD: begin
						cmd_reg       <= rx_byte;
						cmd_seen_reg  <= 1'h1;
						after_ack_reg <= smbus_charger_pkg::SL_DLO;
					end
					smbus_charger_pkg::SL_DLO: begin
						lo_reg        <= rx_byte; // R20
						after_ack_reg <= smbus_charger_pkg::SL_DHI;
					end
					default: begin
						after_ack_reg <= smbus_charger_pkg::SL_SKIP; // R10
					end
					endcase
				end
			end
			smbus_charger_pkg::SL_ACK: begin
				state_reg <= after_ack_reg;
			end
			smbus_charger_pkg::SL_TX: begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (bit_cnt_reg == 4'h7) begin
					bit_cnt_reg <= 4'h0;
					state_reg   <= smbus_charger_pkg::SL_MACK;
				end
			end
			smbus_charger_pkg::SL_MACK: begin
				// Master NACK ends the read; ACK asks for the high byte
				if (sda || tx_hi_reg) begin
					state_reg <= smbus_charger_pkg::SL_SKIP; // R11
				end else begin
					tx_hi_reg <= 1'h1; // R20
					state_reg <= smbus_charger_pkg::SL_TX;
				end
			end
			default: ;
			endcase
		end
	end

	// Setting registers; only DHI completion commits a word
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_charger_config_word      <= `RST_CONFIG;
			o_battery_current_setpoint <= `RST_BATT_CURRENT; // R14
			o_battery_voltage_setpoint <= `RST_BATT_VOLTAGE; // R15
			o_adapter_current_setpoint <= `RST_ADPT_CURRENT; // R16
		end else if (enabled && !stop_cond && !start_cond && scl_rise &&
			state_reg == smbus_charger_pkg::SL_DHI &&
			bit_cnt_reg == 4'h7) begin
			case (cmd_reg)
			`CMD_CONFIG: o_charger_config_word <=
				{rx_byte, lo_reg} & `MASK_CONFIG; // R19
			`CMD_BATT_CURRENT: o_battery_current_setpoint <=
				{rx_byte, lo_reg} & `MASK_BATT_CURRENT; // R14
			`CMD_BATT_VOLTAGE: o_battery_voltage_setpoint <=
				{rx_byte, lo_reg} & `MASK_BATT_VOLTAGE; // R15
			`CMD_ADPT_CURRENT: o_adapter_current_setpoint <=
				{rx_byte, lo_reg} & `MASK_ADPT_CURRENT; // R16
			default: ; // R21
			endcase
		end
	end

	// SDA drive loaded on SCL fall; START, STOP or disable clear it at once
	always_comb begin
		sda_drive_next = 1'h0;
		case (state_reg)
		smbus_charger_pkg::SL_ACK: sda_drive_next = 1'h1; // R12
		smbus_charger_pkg::SL_TX: begin
			sda_drive_next = !(tx_hi_reg ?
				tx_word_reg[4'hf - bit_cnt_reg[2:0]] :
				tx_word_reg[4'h7 - bit_cnt_reg[2:0]]);
		end
		default: sda_drive_next = 1'h0;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sda_drive_reg <= 1'h0;
		end else if (!enabled || stop_cond || start_cond) begin
			sda_drive_reg <= 1'h0;
		end else if (scl_fall) begin
			sda_drive_reg <= sda_drive_next; // R7
		end
	end
	assign bus.sda_dev_out = 1'h0;
	assign bus.sda_dev_oe  = sda_drive_reg; // R2
endmodule // smbus_charger_slave

// ---- rtl/smbus_charger_host.sv ----
// Host master issuing Write-Word and Read-Word transactions
`timescale 1ns/10ps
`include "smbus_charger_params.svh"
module smbus_charger_host (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_req,
	input  wire logic        i_read,
	input  wire logic [7:0]  i_cmd,
	input  wire logic [15:0] i_wdata,
	smbus_charger_if.host    bus,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_nack,
	output logic [15:0]      o_rdata
);
	logic [15:0] div_reg;
	logic        tick;
	logic [1:0]  ph_reg;
	logic [3:0]  bit_reg;
	logic [2:0]  byte_reg;
	logic [2:0]  last_byte;
	logic [7:0]  tx_byte;
	logic [7:0]  rx_reg;
	logic        rd_reg;
	logic [7:0]  cmd_reg;
	logic [15:0] wd_reg;
	logic        scl_low_reg;
	logic        sda_low_reg;
	logic        sda_s1_reg;
	logic        sda_s2_reg;
	logic        sda_pend_reg;
	logic        sda_load_reg;
	smbus_charger_pkg::host_state_t st_reg;
	assign tick = (div_reg == 16'(`SCL_HALF_CYC - 1));
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
		end
	end
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sda_s1_reg <= 1'h1;
			sda_s2_reg <= 1'h1;
		end else begin
			sda_s1_reg <= bus.sda;
			sda_s2_reg <= sda_s1_reg;
		end
	end
	assign last_byte = rd_reg ? 3'h4 : 3'h3;
	always_comb begin
		case (byte_reg)
		3'h0: tx_byte = {`SLAVE_ADDR, 1'b0};
		3'h1: tx_byte = cmd_reg;
		3'h2: tx_byte = rd_reg ? {`SLAVE_ADDR, 1'b1} : wd_reg[7:0];
		3'h3: tx_byte = wd_reg[15:8];
		default: tx_byte = 8'hff;
		endcase
	end
	// Phases per bit: 0 SCL low, SDA a cycle later; 1 SCL high, sample
	// SDA lags SCL so the two lines never move on the same edge
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg <= smbus_charger_pkg::HM_IDLE;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			byte_reg <= 3'h0;
			rx_reg <= 8'h00;
			rd_reg <= 1'h0;
			cmd_reg <= 8'h00;
			wd_reg <= 16'h0000;
			scl_low_reg <= 1'h0;
			sda_low_reg <= 1'h0;
			sda_pend_reg <= 1'h0;
			sda_load_reg <= 1'h0;
			o_busy <= 1'h0;
			o_done <= 1'h0;
			o_nack <= 1'h0;
			o_rdata <= 16'h0000;
		end else begin
			o_done <= 1'h0;
			sda_load_reg <= 1'h0;
			if (sda_load_reg) begin
				sda_low_reg <= sda_pend_reg; // R7
			end
			case (st_reg)
			smbus_charger_pkg::HM_IDLE: if (i_req) begin
				rd_reg <= i_read;
				cmd_reg <= i_cmd;
				wd_reg <= i_wdata;
				o_busy <= 1'h1;
				o_nack <= 1'h0;
				byte_reg <= 3'h0;
				st_reg <= smbus_charger_pkg::HM_START;
			end
			smbus_charger_pkg::HM_START: if (tick) begin
				sda_low_reg <= 1'h1; // R5
				bit_reg <= 4'h0;
				ph_reg <= 2'h0;
				st_reg <= smbus_charger_pkg::HM_BIT;
			end
			smbus_charger_pkg::HM_RSTART: if (tick) begin
				ph_reg <= ph_reg + 2'h1;
				case (ph_reg)
				2'h0: scl_low_reg <= 1'h1; // Close the ack clock first
				2'h1: scl_low_reg <= 1'h0;
				default: begin
					sda_low_reg <= 1'h1;
					ph_reg <= 2'h0;
					st_reg <= smbus_charger_pkg::HM_BIT;
				end
				endcase
			end
			smbus_charger_pkg::HM_BIT: if (tick) begin
				ph_reg <= ph_reg ^ 2'h1;
				if (ph_reg == 2'h0) begin
					scl_low_reg <= 1'h1;
					sda_load_reg <= 1'h1;
					if (bit_reg < 4'h8) begin
						sda_pend_reg <= (rd_reg && byte_reg > 3'h2) ? 1'h0
							: !tx_byte[3'h7 - bit_reg[2:0]];
					end else begin
						sda_pend_reg <= rd_reg && byte_reg == 3'h3;
					end
				end else begin
					scl_low_reg <= 1'h0;
					bit_reg <= bit_reg + 4'h1;
					if (bit_reg < 4'h8) begin
						rx_reg <= {rx_reg[6:0], sda_s2_reg};
					end else begin
						bit_reg <= 4'h0;
						byte_reg <= byte_reg + 3'h1;
						// Every slave-acked byte is checked, last one too
						if ((!rd_reg || byte_reg < 3'h3) && sda_s2_reg) begin
							o_nack <= 1'h1;
							st_reg <= smbus_charger_pkg::HM_STOP;
						end else if (byte_reg == last_byte) begin
							st_reg <= smbus_charger_pkg::HM_STOP;
						end else if (rd_reg && byte_reg == 3'h1) begin
							st_reg <= smbus_charger_pkg::HM_RSTART;
						end
						if (rd_reg && byte_reg == 3'h3) begin
							o_rdata[7:0] <= rx_reg;
						end
						if (rd_reg && byte_reg == 3'h4) begin
							o_rdata[15:8] <= rx_reg;
						end
					end
				end
			end
			smbus_charger_pkg::HM_STOP: if (tick) begin
				ph_reg <= ph_reg + 2'h1;
				case (ph_reg)
				2'h0: begin
					scl_low_reg <= 1'h1;
					sda_pend_reg <= 1'h1;
					sda_load_reg <= 1'h1;
				end
				2'h1: scl_low_reg <= 1'h0;
				default: begin
					sda_low_reg <= 1'h0; // R6
					ph_reg <= 2'h0;
					st_reg <= smbus_charger_pkg::HM_DONE;
				end
				endcase
			end
			default: begin
				o_busy <= 1'h0;
				o_done <= 1'h1;
				st_reg <= smbus_charger_pkg::HM_IDLE;
			end
			endcase
		end
	end
	assign bus.scl_out = 1'h0;
	assign bus.scl_oe = scl_low_reg;
	assign bus.sda_host_out = 1'h0;
	assign bus.sda_host_oe = sda_low_reg;
endmodule // smbus_charger_host

// ---- testbench/smbus_charger_checker.sv ----
// Assertions on the two-wire bus between the charger slave and host
`timescale 1ns/10ps
module smbus_charger_checker (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe,
	input wire logic sda_host_out,
	input wire logic sda_host_oe,
	input wire logic scl,
	input wire logic sda
);
	// Ack plus an all-zero byte is the longest legal low drive
	localparam int hold_max = 1850;
	logic [10:0] oe_run;
	logic        bus_idle;
	logic        sda_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sda_q <= 1'b1;
		end else begin
			sda_q <= sda;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bus_idle <= 1'b1;
		end else if (scl && sda_q && !sda) begin
			bus_idle <= 1'b0;
		end else if (scl && !sda_q && sda) begin
			bus_idle <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			oe_run <= 11'h000;
		end else if (sda_dev_oe) begin
			oe_run <= oe_run + 11'h001;
		end else begin
			oe_run <= 11'h000;
		end
	end

	chk_dev_sda_edge: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("slave moved SDA while SCL high");
	chk_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_out)
		else $error("slave drives SDA high");
	chk_ack_hold: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
		else $error("slave low drive too short");
	chk_dev_hold_bound: assert property (oe_run <= hold_max)
		else $error("slave holds SDA low too long");
	chk_start_by_host: assert property (s_start |-> sda_host_oe && !sda_dev_oe)
		else $error("start not made by host");
	chk_stop_release: assert property (s_stop |=> !sda_dev_oe[*4])
		else $error("slave drives SDA after stop");
	chk_idle_silent: assert property (bus_idle |-> !sda_dev_oe)
		else $error("slave drives idle bus");
	chk_scl_low_span: assert property ($fell(scl) |-> !scl[*8] ##[1:300] scl)
		else $error("SCL low phase out of range");
	chk_host_sda_edge: assert property (
		$changed(sda_host_oe) |-> $stable(scl))
		else $error("host moved SDA on an SCL edge");
	chk_host_open_drain: assert property (
		(scl_oe || sda_host_oe) |-> !(scl_out || sda_host_out))
		else $error("host drives a line high");
endmodule // smbus_charger_checker

// ---- testbench/tb_top.sv ----
// Bench joining the charger slave and host over the two-wire bus
`timescale 1ns/10ps
`include "smbus_charger_params.svh"
module tb_top;
	localparam logic [15:0] maker_id = 16'h0c3a; // Arbitrary value
	localparam logic [15:0] part_id  = 16'h05c3; // Arbitrary value
	logic        i_ref_clk;
	logic        i_sys_rst;
	logic        supply_ok;
	logic        adapter_ok;
	logic        req;
	logic        rd;
	logic [7:0]  cmd;
	logic [15:0] wdata;
	logic        busy;
	logic        done;
	logic        nack;
	logic [15:0] rdata;
	logic [15:0] cfg_w;
	logic [15:0] bcur_w;
	logic [15:0] bvolt_w;
	logic [15:0] acur_w;
	logic [63:0] wire_bits;
	logic        bit_q;
	logic        pend;
	int          wire_cnt;
	int          failures;
	int          checks_done;

	smbus_charger_if bus ();
	smbus_charger_slave #(.MAKER_CODE(maker_id), .PART_CODE(part_id))
		u_smbus_charger_slave (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_supply_ok(supply_ok), .i_adapter_detect_input(adapter_ok),
		.bus(bus.device), .o_charger_config_word(cfg_w),
		.o_battery_current_setpoint(bcur_w),
		.o_battery_voltage_setpoint(bvolt_w),
		.o_adapter_current_setpoint(acur_w));
	smbus_charger_host u_smbus_charger_host (.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst), .i_req(req), .i_read(rd), .i_cmd(cmd),
		.i_wdata(wdata), .bus(bus.host), .o_busy(busy), .o_done(done),
		.o_nack(nack), .o_rdata(rdata));
	smbus_charger_checker u_smbus_charger_checker (.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst), .scl_out(bus.scl_out), .scl_oe(bus.scl_oe),
		.sda_dev_out(bus.sda_dev_out), .sda_dev_oe(bus.sda_dev_oe),
		.sda_host_out(bus.sda_host_out), .sda_host_oe(bus.sda_host_oe),
		.scl(bus.scl), .sda(bus.sda));

	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	// Bit is committed on the SCL fall, so the rise before STOP drops out
	always @(posedge bus.scl) begin
		bit_q = bus.sda;
		pend = 1'b1;
	end
	always @(negedge bus.scl) begin
		if (pend === 1'b1) begin
			wire_bits = {wire_bits[62:0], bit_q};
			wire_cnt = wire_cnt + 1;
		end
		pend = 1'b0;
	end
	always @(negedge bus.sda) begin
		if (bus.scl === 1'b1) begin
			wire_cnt = 0;
			pend = 1'b0;
		end
	end

	task automatic check_word(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_wire(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xfer(input logic r, input logic [7:0] c,
		input logic [15:0] d);
		int n;
		@(posedge i_ref_clk);
		#1;
		rd = r;
		cmd = c;
		wdata = d;
		req = 1'b1;
		@(posedge i_ref_clk);
		#1;
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 30000) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		if (n >= 30000) begin
			failures++;
			$display("Error done expected 1 seen %b", done);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s finished", name);
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#2400000;
		failures++;
		stop_test();
	end

	initial begin
		i_sys_rst = 1'b1;
		supply_ok = 1'b1;
		adapter_ok = 1'b1;
		req = 1'b0;
		rd = 1'b0;
		cmd = 8'h00;
		wdata = 16'h0000;
		wire_bits = 64'h0;
		wire_cnt = 0;
		pend = 1'b0;
		bit_q = 1'b0;
		failures = 0;
		checks_done = 0;
		repeat (16) @(posedge i_ref_clk);
		#1;
		i_sys_rst = 1'b0;
		check_word("config", `RST_CONFIG, cfg_w);
		check_word("batt current", 16'h0000, bcur_w);
		check_word("batt voltage", 16'h0000, bvolt_w);
		check_word("adapter current", 16'h1000, acur_w);
		check_wire("idle lines", 64'h3, {bus.scl, bus.sda});
		end_test("reset");
		xfer(1'b1, 8'h3f, 16'h0000);
		check_word("read 3f", 16'h1000, rdata);
		check_word("nack", 16'h0000, {15'h0, nack});
		check_wire("read bits", 27, wire_cnt);
		check_wire("read frame", {8'h13, 1'b0, 8'h00, 1'b0, 8'h10, 1'b1},
			wire_bits[26:0]);
		end_test("read word");
		xfer(1'b0, 8'h14, 16'hc07f);
		check_word("batt current", 16'h0040, bcur_w);
		check_wire("write bits", 36, wire_cnt);
		check_wire("write frame", {8'h12, 1'b0, 8'h14, 1'b0, 8'h7f, 1'b0,
			8'hc0, 1'b0}, wire_bits[35:0]);
		xfer(1'b1, 8'h14, 16'h0000);
		check_word("read 14", 16'h0040, rdata);
		end_test("write word");
		xfer(1'b0, 8'hfe, 16'h1234);
		check_wire("settings", {16'h7904, 16'h0040, 16'h0000, 16'h1000},
			{cfg_w, bcur_w, bvolt_w, acur_w});
		xfer(1'b1, 8'hfe, 16'h0000);
		check_word("read fe", maker_id, rdata);
		xfer(1'b1, 8'hff, 16'h0000);
		check_word("read ff", part_id, rdata);
		end_test("identity");
		xfer(1'b0, 8'h12, 16'habcd);
		check_word("config", 16'habcd & `MASK_CONFIG, cfg_w);
		xfer(1'b1, 8'h12, 16'h0000);
		check_word("read 12", 16'habcd & `MASK_CONFIG, rdata);
		end_test("options");
		for (int i = 0; i < 2; i++) begin
			supply_ok = (i == 1);
			adapter_ok = (i == 0);
			repeat (8) @(posedge i_ref_clk);
			xfer(1'b0, 8'h15, 16'hffff);
			check_word("nack", 16'h0001, {15'h0, nack});
			check_word("batt voltage", 16'h0000, bvolt_w);
			check_wire("address ack", {8'h12, 1'b1}, wire_bits[8:0]);
		end
		supply_ok = 1'b1;
		adapter_ok = 1'b1;
		end_test("disabled");
		stop_test();
	end
endmodule // tb_top
